// File: logic/pmi_top.sv
// management serial slave with latched interrupt status and indicator routing
//
// What this block does
// RULE1 - the station supplies the management clock at any rate from static up to 8.33 MHz.
// RULE2 - the data line is two-way and each bit moves with the management clock.
// RULE3 - the internal registers are reached only over the two-wire management link.
// RULE4 - frame: 01, opcode 10 read or 01 write, two addresses, turnaround, 16 data bits, idle.
// RULE5 - frames without preamble are always accepted.
// RULE6 - the station leaves at least one idle bit between operations.
// RULE7 - routing field 1110 in the LED control register puts the interrupt on indicator pin two.
// RULE8 - bit 14 of the specific control register selects the interrupt's active level.
// RULE9 - the enable register holds enables for bits 14..6, 4, 1 and 0.
// RULE10 - an event sets its status bit whatever its enable.
// RULE11 - status bits stay set until the status register is read, which clears them.
// RULE12 - the pin is asserted while routed and some status bit has its enable set.
// RULE13 - the pin drops when the status read clears the bits or when the enables are written off.
// RULE14 - frames for another device address are ignored and the line is not driven.
// RULE15 - bits are sampled on the rising clock edge; read data changes only after that edge.
`timescale 1ns/1ps
`include "pmi_regs.svh"
module pmi_top (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // management link
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    // configured device address
    input wire logic [4:0] dev_addr,
    // event pulses, one per status bit
    input wire logic [15:0] irq_event,
    // normal indication and pin output
    input wire logic led_two_normal,
    output logic indicator_pin_two
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers

    logic mdc_s1_r;
    logic mdc_s2_r;
    logic mdc_d_r;
    logic dio_s1_r;
    logic dio_s2_r;
    logic [4:0] adr_s1_r;
    logic [4:0] adr_s2_r;
    logic led_s1_r;
    logic led_s2_r;
    logic mdc_rise;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mdc_s1_r <= 1'h0;
            mdc_s2_r <= 1'h0;
            mdc_d_r <= 1'h0;
            dio_s1_r <= 1'h1;
            dio_s2_r <= 1'h1;
            adr_s1_r <= 5'h00;
            adr_s2_r <= 5'h00;
            led_s1_r <= 1'h0;
            led_s2_r <= 1'h0;
        end else begin
            mdc_s1_r <= mdc_in;
            mdc_s2_r <= mdc_s1_r;
            mdc_d_r <= mdc_s2_r;
            dio_s1_r <= mdio_in;
            dio_s2_r <= dio_s1_r;
            adr_s1_r <= dev_addr;
            adr_s2_r <= adr_s1_r;
            led_s1_r <= led_two_normal;
            led_s2_r <= led_s1_r;
        end
    end

    // any clock rate works while its high and low phases each last longer than a system clock, the edge is found by oversampling
    assign mdc_rise = mdc_s2_r & ~mdc_d_r; // RULE15 RULE1

////////////////////////////////////////////////////////////////////////////////
// frame receiver

    pmi_pkg::pmi_state_t state_r;
    logic [3:0] cnt_r;
    logic [11:0] hdr_r;
    logic [15:0] din_r;
    logic hdr_done;
    logic [11:0] hdr_full;
    logic rd_hit;
    logic wr_hit;
    logic wr_commit;

    assign hdr_full = {hdr_r[10:0], dio_s2_r};
    assign hdr_done = mdc_rise && state_r == pmi_pkg::ST_HDR && cnt_r == `PMI_HDR_LAST;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= pmi_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            hdr_r <= 12'h000;
            din_r <= 16'h0000;
        end else if (mdc_rise) begin
            unique case (state_r)
                // no preamble needed: a 0 after idle opens the start pattern
                pmi_pkg::ST_IDLE: begin
                    if (!dio_s2_r) begin
                        state_r <= pmi_pkg::ST_START; // RULE5
                    end
                end
                pmi_pkg::ST_START: begin
                    if (dio_s2_r) begin
                        state_r <= pmi_pkg::ST_HDR; // RULE4
                        cnt_r <= 4'h0;
                    end
                end
                pmi_pkg::ST_HDR: begin
                    hdr_r <= hdr_full;
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == `PMI_HDR_LAST) begin
                        state_r <= pmi_pkg::ST_TA;
                        cnt_r <= 4'h0;
                    end
                end
                pmi_pkg::ST_TA: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == `PMI_TA_LAST) begin
                        state_r <= pmi_pkg::ST_DATA;
                        cnt_r <= 4'h0;
                    end
                end
                pmi_pkg::ST_DATA: begin
                    din_r <= {din_r[14:0], dio_s2_r};
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == `PMI_DATA_LAST) begin
                        state_r <= pmi_pkg::ST_IDLE;
                        cnt_r <= 4'h0;
                    end
                end
            endcase
        end
    end

    // hdr_r: [11:10] opcode, [9:5] device address, [4:0] register address
    assign rd_hit = hdr_full[11:10] == `PMI_OP_RD && hdr_full[9:5] == adr_s2_r; // RULE14
    assign wr_hit = hdr_r[11:10] == `PMI_OP_WR && hdr_r[9:5] == adr_s2_r; // RULE14
    assign wr_commit = mdc_rise && state_r == pmi_pkg::ST_DATA && cnt_r == `PMI_DATA_LAST
        && wr_hit;

////////////////////////////////////////////////////////////////////////////////
// register file

    logic [15:0] irq_en_r;
    logic [15:0] irq_st_r;
    logic [15:0] led_ctl_r;
    logic [15:0] spec_ctl_r;
    logic [15:0] wr_data;
    logic [15:0] rd_mux;
    logic st_clear;

    assign wr_data = {din_r[14:0], dio_s2_r};

    always_comb begin
        unique case (hdr_full[4:0])
            `PMI_REG_IRQ_EN: rd_mux = irq_en_r;
            `PMI_REG_IRQ_ST: rd_mux = irq_st_r;
            `PMI_REG_LED_CTL: rd_mux = led_ctl_r;
            `PMI_REG_SPEC_CTL: rd_mux = spec_ctl_r;
            default: rd_mux = 16'h0000;
        endcase
    end

    assign st_clear = hdr_done && rd_hit && hdr_full[4:0] == `PMI_REG_IRQ_ST; // RULE11

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_en_r <= `PMI_IRQ_EN_RST;
            led_ctl_r <= `PMI_LED_CTL_RST;
            spec_ctl_r <= `PMI_SPEC_CTL_RST;
        end else if (wr_commit) begin
            unique case (hdr_r[4:0])
                `PMI_REG_IRQ_EN: irq_en_r <= wr_data & `PMI_IRQ_IMPL; // RULE9 RULE3
                `PMI_REG_LED_CTL: led_ctl_r <= wr_data;
                `PMI_REG_SPEC_CTL: spec_ctl_r <= wr_data;
                default: irq_en_r <= irq_en_r;
            endcase
        end
    end

    // an event in the clearing cycle survives the clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_st_r <= `PMI_IRQ_ST_RST;
        end else begin
            irq_st_r <= ((st_clear ? 16'h0000 : irq_st_r) | irq_event) // RULE10 RULE11
                & `PMI_IRQ_IMPL;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// read data driver

    logic [15:0] dout_r;
    logic rd_act_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dout_r <= 16'h0000;
            rd_act_r <= 1'h0;
            mdio_out <= 1'h1;
            mdio_oe_n <= 1'h1;
        end else if (mdc_rise) begin
            if (hdr_done) begin
                // first turnaround bit stays released
                dout_r <= rd_mux;
                rd_act_r <= rd_hit; // RULE14
            end else if (state_r == pmi_pkg::ST_TA && cnt_r == 4'h0 && rd_act_r) begin
                mdio_out <= 1'h0; // RULE4 RULE2
                mdio_oe_n <= 1'h0;
            end else if (state_r == pmi_pkg::ST_TA && rd_act_r) begin
                mdio_out <= dout_r[15]; // RULE15
                dout_r <= {dout_r[14:0], 1'h0};
            end else if (state_r == pmi_pkg::ST_DATA && rd_act_r) begin
                if (cnt_r == `PMI_DATA_LAST) begin
                    mdio_out <= 1'h1;
                    mdio_oe_n <= 1'h1;
                    rd_act_r <= 1'h0;
                end else begin
                    mdio_out <= dout_r[15]; // RULE15
                    dout_r <= {dout_r[14:0], 1'h0};
                end
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// interrupt routing

    logic irq_pend;
    logic routed;

    assign irq_pend = |(irq_st_r & irq_en_r); // RULE12 RULE13
    assign routed = led_ctl_r[`PMI_ROUTE_MSB:`PMI_ROUTE_LSB] == `PMI_ROUTE_IRQ; // RULE7

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            indicator_pin_two <= 1'h0;
        end else if (routed) begin
            indicator_pin_two <= irq_pend ~^ spec_ctl_r[`PMI_POL_BIT]; // RULE8 RULE12
        end else begin
            indicator_pin_two <= led_s2_r; // RULE7
        end
    end

endmodule

// File: logic/pmi_regs.svh
// register offsets, field positions, reset values and frame counts
`ifndef PMI_REGS_SVH
`define PMI_REGS_SVH
`define PMI_REG_IRQ_EN 5'h12
`define PMI_REG_IRQ_ST 5'h13
`define PMI_REG_LED_CTL 5'h16
`define PMI_REG_SPEC_CTL 5'h19
`define PMI_IRQ_EN_RST 16'h0000
`define PMI_IRQ_ST_RST 16'h0000
`define PMI_LED_CTL_RST 16'h0000
`define PMI_SPEC_CTL_RST 16'h0000
`define PMI_IRQ_IMPL 16'h7FD3
`define PMI_ROUTE_LSB 8
`define PMI_ROUTE_MSB 11
`define PMI_ROUTE_IRQ 4'hE
`define PMI_POL_BIT 14
`define PMI_OP_RD 2'h2
`define PMI_OP_WR 2'h1
`define PMI_HDR_LAST 4'hB
`define PMI_TA_LAST 4'h1
`define PMI_DATA_LAST 4'hF
`endif

// File: logic/pmi_pkg.sv
// types shared by the management serial block
package pmi_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_HDR,
        ST_TA,
        ST_DATA
    } pmi_state_t;
endpackage

// File: bench/pmi_sva.sv
// assertions on the management link and the indicator pin
`timescale 1ns/1ps
module pmi_sva (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // link and pins
    input wire logic mdc_in,
    input wire logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    input wire logic [4:0] dev_addr,
    input wire logic [15:0] irq_event,
    input wire logic led_two_normal,
    input wire logic indicator_pin_two
);
    logic [4:0] lo_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // cycles since the link clock was last high
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) lo_r <= 5'h00;
        else if (mdc_in) lo_r <= 5'h00;
        else if (lo_r != 5'h1F) lo_r <= lo_r + 5'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    ta_zero_a: assert property ($fell(mdio_oe_n) |-> !mdio_out)
        else $error("turnaround bit not zero");
    drive_hold_a: assert property ($fell(mdio_oe_n) |-> !mdio_oe_n [*8])
        else $error("drive dropped early");
    drive_len_a: assert property ($fell(mdio_oe_n) |-> ##[128:140] $rose(mdio_oe_n))
        else $error("read drive not seventeen bits");
    bit_edge_a: assert property (!mdio_oe_n && $changed(mdio_out) |->
        $past(mdc_in, 2) || $past(mdc_in, 3) || $past(mdc_in, 4))
        else $error("data moved off edge");
    oe_edge_a: assert property ($changed(mdio_oe_n) |->
        $past(mdc_in, 2) || $past(mdc_in, 3) || $past(mdc_in, 4))
        else $error("enable moved off edge");
    rise_stable_a: assert property ($rose(mdc_in) && !mdio_oe_n |->
        $stable(mdio_out) [*2]) else $error("data moved at sample");
    idle_free_a: assert property (lo_r == 5'h1F |-> mdio_oe_n)
        else $error("line driven while idle");
    pin_cause_a: assert property ($changed(indicator_pin_two) |->
        (|($past(irq_event, 2) & 16'h7FD3)) || $past(led_two_normal, 2) != $past(led_two_normal, 5)
        || $past(mdc_in, 4) || $past(mdc_in, 5) || $past(mdc_in, 6))
        else $error("pin moved uncaused");
endmodule

// File: bench/pmi_station.sv
// station model driving the management clock and data line
`timescale 1ns/1ps
module pmi_station (
    input wire logic clk,
    output logic mdc,
    output logic sd,
    output logic soe,
    input wire logic mdio
);
    initial begin
        mdc = 1'h0;
        sd = 1'h1;
        soe = 1'h0;
    end
    // one frame, no preamble, then one idle bit; clock still after
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, output logic [15:0] rd);
        logic [32:0] f;
        f = {2'h1, op, pa, ra, 2'h2, wd, 1'h1};
        rd = 16'h0000;
        @(posedge clk);
        #1;
        for (int i = 0; i < 33; i++) begin
            mdc = 1'h0;
            soe = i < 14 || (op == 2'h1 && i < 32);
            sd = soe ? f[32-i] : ~sd;
            #16 mdc = 1'h1;
            if (i > 15 && i < 32) rd = {rd[14:0], mdio};
            #16;
        end
        mdc = 1'h0;
    endtask
endmodule

// File: bench/pmi_top_tb.sv
// testbench for the management serial block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module pmi_top_tb;
    localparam logic [4:0] PHY = 5'h0B;
    logic clock, nrst, mdc, sd, soe, mdio_w, mdio_out, mdio_oe_n, led, pin;
    logic [15:0] irq_event, rd;
    int n_errors, n_checks;
    // pull-up wins when nobody drives
    assign mdio_w = soe ? sd : (!mdio_oe_n ? mdio_out : 1'b1);
    pmi_station u_sta (.clk(clock), .mdc(mdc), .sd(sd), .soe(soe), .mdio(mdio_w));
    pmi_top u_dut (.clock(clock), .nrst(nrst), .mdc_in(mdc), .mdio_in(mdio_w),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .dev_addr(PHY), .irq_event(irq_event),
        .led_two_normal(led), .indicator_pin_two(pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        u_sta.xfer(2'h1, PHY, a, d, rd);
    endtask
    task automatic rg(input logic [4:0] a, input logic [15:0] e);
        u_sta.xfer(2'h2, PHY, a, 16'h0000, rd);
        `CHK(rd, e)
    endtask
    task automatic ev(input logic [15:0] v);
        @(posedge clock);
        #1 irq_event = v;
        @(posedge clock);
        #1 irq_event = 16'h0000;
    endtask
    task automatic pn(input logic e);
        repeat (8) @(posedge clock);
        #1;
        `CHK(pin, e)
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rg(5'h12, 16'h0000);
        rg(5'h13, 16'h0000);
        wr(5'h12, 16'hFFFF);
        rg(5'h12, 16'h7FD3);
        u_sta.xfer(2'h1, PHY ^ 5'h01, 5'h12, 16'h0000, rd);
        rg(5'h12, 16'h7FD3);
        u_sta.xfer(2'h2, PHY ^ 5'h01, 5'h12, 16'h0000, rd);
        `CHK(rd, 16'hFFFF)
        u_sta.xfer(2'h3, PHY, 5'h12, 16'h0000, rd);
        `CHK(rd, 16'hFFFF)
        rg(5'h12, 16'h7FD3);
        wr(5'h05, 16'h1234);
        rg(5'h05, 16'h0000);
        wr(5'h12, 16'h0000);
        $display("test regs done");
    endtask
    task automatic t_irq;
        wr(5'h16, 16'h0E00);
        wr(5'h19, 16'h4000);
        ev(16'hFFFF);
        pn(1'h0);
        rg(5'h13, 16'h7FD3);
        rg(5'h13, 16'h0000);
        wr(5'h12, 16'h0001);
        ev(16'h0001);
        pn(1'h1);
        rg(5'h13, 16'h0001);
        pn(1'h0);
        ev(16'h0001);
        pn(1'h1);
        wr(5'h12, 16'h0000);
        pn(1'h0);
        wr(5'h19, 16'h0000);
        pn(1'h1);
        wr(5'h12, 16'h0001);
        pn(1'h0);
        wr(5'h16, 16'h0000);
        @(posedge clock);
        #1 led = 1'h1;
        pn(1'h1);
        $display("test irq done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #2 clock = ~clock;
    end
    initial begin
        #100000;
        n_errors++;
        close_out();
    end
    initial begin
        nrst = 1'h0;
        led = 1'h0;
        irq_event = 16'h0000;
        n_errors = 0;
        n_checks = 0;
        repeat (2) @(posedge clock);
        #1 nrst = 1'h1;
        repeat (4) @(posedge clock);
        t_regs();
        t_irq();
        close_out();
    end
endmodule
bind pmi_top pmi_sva u_sva (.clock(clock), .nrst(nrst), .mdc_in(mdc_in), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .dev_addr(dev_addr), .irq_event(irq_event),
    .led_two_normal(led_two_normal), .indicator_pin_two(indicator_pin_two));
